//--- logic/bcs_pkg.sv
// Shared types and constants of the branch cycle sequencer
package bcs_pkg;

    // ************************************************************
    // Instruction lengths and fixed values
    // ************************************************************
    localparam logic [31:0] BCS_STEP_WIDE    = 32'h0000_0004;
    localparam logic [31:0] BCS_STEP_COMPACT = 32'h0000_0002;
    localparam logic [31:0] BCS_WORD_MASK    = 32'hFFFF_FFFC;
    localparam logic [31:0] BCS_HALF_MASK    = 32'hFFFF_FFFE;
    localparam logic [31:0] BCS_ADDR_RESET   = 32'h0000_0000;
    localparam logic [3:0]  BCS_LINK_REG     = 4'he;
    localparam logic [2:0]  BCS_COST_RESET   = 3'h0;
    localparam logic [1:0]  BCS_ILK_RESET    = 2'h0;

    // ************************************************************
    // Branch kinds
    // ************************************************************
    typedef enum logic [2:0] {
        BCS_K_BRANCH  = 3'h0,
        BCS_K_LINK    = 3'h1,
        BCS_K_XREG    = 3'h2,
        BCS_K_LXREG   = 3'h3,
        BCS_K_LXIMM   = 3'h4,
        BCS_K_CLINK   = 3'h5,
        BCS_K_CLXIMM  = 3'h6
    } bcs_kind_type;

    // ************************************************************
    // Command from decode and target results
    // ************************************************************
    typedef struct packed {
        logic         valid;
        bcs_kind_type kind;
        logic         compact;
        logic         prev_data;
        logic [1:0]   interlock;
        logic [31:0]  pc;
        logic [31:0]  imm_hi;
        logic [31:0]  imm_lo;
        logic [31:0]  reg_val;
    } bcs_cmd_type;

    typedef struct packed {
        logic [31:0] target;
        logic        new_compact;
        logic [31:0] hi_sum;
        logic [31:0] ret_addr;
        logic        link;
        logic        two_part;
        logic        reg_form;
    } bcs_calc_type;

endpackage

//--- logic/bcs_sequencer.sv
// Branch cycle sequencer: execute cycles and fetch-side outputs of branches
// Operation
// - Cost counts execute-stage cycles only; other stages take one each.
// - Interlock cycles are charged to the producing instruction, not the branch.
// - Fetch and data controls are driven one cycle ahead of use.
// - Sequential fetch steps 4 bytes wide, 2 bytes compact.
// - Low wait gate stretches every cycle; counts are zero-wait figures.
// - Plain branch and wide linked branch take three execute cycles.
// - Cycle one computes target, prefetch happens, pending data transfer completes.
// - Cycle two fetches target; linked forms compute return address for r14.
// - Cycle three fetches target plus one length, refilling the pipe.
// - Plain branch fetches target nonsequential, then two sequential; data idle.
// - Compact linked branch is two instructions taking four cycles.
// - First half adds pc and upper offset into r14, finishes data.
// - Second half: prefetch, target fetch with return address, then target plus 2.
// - Compact linked branch fetches pc+3i sequential, then target nonsequential.
// - Exchange takes three cycles; register forms give target and state.
// - Exchange takes new state from register bit 0, immediate form goes compact; data finishes in cycle one unless interlocked.
// - Exchange fetches use new width; refill at target plus 2 or 4.
// - Exchange shows new state from cycle two; steps by new width.
// - Compact link-exchange takes four cycles, refill at target plus 4.
// - Compact link-exchange shows old state in cycles one and two, new after.
`timescale 1ns/1ns
module bcs_sequencer (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 wait_state_gate,
    input  wire bcs_pkg::bcs_cmd_type cmd,
    output logic                      cmd_ready,
    output logic [31:0]               read_word_a_fetch_addr,
    output logic                      read_word_a_mem_req_n,
    output logic                      read_word_a_sequential,
    output logic                      compact_state_out,
    output logic [31:0]               data_side_addr,
    output logic                      data_mem_req_n,
    output logic                      data_sequential,
    output logic                      data_xfer_done,
    output logic                      prefetch_discard,
    output logic                      link_we,
    output logic [3:0]                link_idx,
    output logic [31:0]               link_data,
    output logic                      retire,
    output logic [2:0]                retire_cost,
    output logic                      charge_valid,
    output logic [1:0]                charge_cycles
);
    import bcs_pkg::*;

    // ************************************************************
    // State and registers
    // ************************************************************
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ILK  = 6'b000010,
        S_HALF = 6'b000100,
        S_B1   = 6'b001000,
        S_B2   = 6'b010000,
        S_B3   = 6'b100000
    } bcs_state_type;

    bcs_state_type state_q, state_d;
    bcs_cmd_type   cmd_q, cmd_d;
    bcs_calc_type  calc_now;
    bcs_calc_type  calc_q, calc_d;
    logic [31:0]   step_old;
    logic [31:0]   step_new;
    logic [31:0]   fa_q, fa_d;
    logic          freq_n_q, freq_n_d;
    logic          fseq_q, fseq_d;
    logic          comp_q, comp_d;
    logic          xfer_q, xfer_d;
    logic          xfer_pend_q, xfer_pend_d;
    logic          disc_q, disc_d;
    logic          lwe_q, lwe_d;
    logic [31:0]   ldata_q, ldata_d;
    logic          ret_q, ret_d;
    logic [2:0]    cnt_q, cnt_d;
    logic [2:0]    cost_q, cost_d;
    logic [1:0]    ilk_q, ilk_d;
    logic          chg_q, chg_d;
    logic [1:0]    chgn_q, chgn_d;
    logic          take;

    bcs_target_calc u_calc (
        .cmd  (cmd_q),
        .calc (calc_now)
    );

    assign take     = cmd.valid && state_q == S_IDLE;
    assign step_old = cmd_q.compact ? BCS_STEP_COMPACT : BCS_STEP_WIDE;
    assign step_new = calc_q.new_compact ? BCS_STEP_COMPACT : BCS_STEP_WIDE;

    // ************************************************************
    // Next-value logic
    // ************************************************************
    always_comb begin
        state_d     = state_q;
        cmd_d       = cmd_q;
        calc_d      = calc_q;
        fa_d        = fa_q;
        freq_n_d    = freq_n_q;
        fseq_d      = fseq_q;
        comp_d      = comp_q;
        xfer_d      = xfer_q;
        xfer_pend_d = xfer_pend_q;
        disc_d      = disc_q;
        lwe_d       = lwe_q;
        ldata_d     = ldata_q;
        ret_d       = ret_q;
        cnt_d       = cnt_q;
        cost_d      = cost_q;
        ilk_d       = ilk_q;
        chg_d       = chg_q;
        chgn_d      = chgn_q;
        // Low gate holds everything, so each cycle just lasts longer
        if (wait_state_gate) begin
            xfer_d   = 1'b0;
            disc_d   = 1'b0;
            lwe_d    = 1'b0;
            ret_d    = 1'b0;
            chg_d    = 1'b0;
            freq_n_d = 1'b1;
            fseq_d   = 1'b0;
            unique case (state_q)
                S_IDLE: begin
                    if (take) begin
                        cmd_d       = cmd;
                        cnt_d       = BCS_COST_RESET;
                        xfer_pend_d = cmd.prev_data;
                        ilk_d       = BCS_ILK_RESET;
                        state_d     = S_B1;
                        if (cmd.kind == BCS_K_CLINK || cmd.kind == BCS_K_CLXIMM) begin
                            state_d = S_HALF;
                        end else if ((cmd.kind == BCS_K_XREG || cmd.kind == BCS_K_LXREG)
                                     && cmd.interlock != BCS_ILK_RESET) begin
                            state_d = S_ILK;
                        end
                    end
                end
                S_ILK: begin
                    // Stall belongs to the producer; finishes its data here
                    ilk_d = ilk_q + 2'h1;
                    if (xfer_pend_q) begin
                        xfer_d      = 1'b1;
                        xfer_pend_d = 1'b0;
                    end
                    if (ilk_q + 2'h1 == cmd_q.interlock) begin
                        chg_d   = 1'b1;
                        chgn_d  = cmd_q.interlock;
                        state_d = S_B1;
                    end
                end
                S_HALF: begin
                    calc_d   = calc_now;
                    cnt_d    = cnt_q + 3'h1;
                    lwe_d    = 1'b1;
                    ldata_d  = calc_now.hi_sum;
                    xfer_d   = xfer_pend_q;
                    xfer_pend_d = 1'b0;
                    // Sequential prefetch ahead of the second half
                    fa_d     = cmd_q.pc + step_old + step_old + step_old;
                    freq_n_d = 1'b0;
                    fseq_d   = 1'b1;
                    comp_d   = cmd_q.compact;
                    state_d  = S_B1;
                end
                S_B1: begin
                    calc_d   = calc_now;
                    cnt_d    = cnt_q + 3'h1;
                    xfer_d   = xfer_pend_q;
                    xfer_pend_d = 1'b0;
                    // Target requested one cycle ahead, nonsequential
                    fa_d     = calc_now.target;
                    freq_n_d = 1'b0;
                    fseq_d   = 1'b0;
                    comp_d   = calc_now.new_compact;
                    disc_d   = 1'b1;
                    state_d  = S_B2;
                end
                S_B2: begin
                    cnt_d    = cnt_q + 3'h1;
                    lwe_d    = calc_q.link;
                    ldata_d  = calc_q.ret_addr;
                    fa_d     = calc_q.target + step_new;
                    freq_n_d = 1'b0;
                    fseq_d   = 1'b1;
                    state_d  = S_B3;
                end
                S_B3: begin
                    // Refill fetch at target plus two lengths
                    fa_d     = calc_q.target + step_new + step_new;
                    freq_n_d = 1'b0;
                    fseq_d   = 1'b1;
                    ret_d    = 1'b1;
                    cost_d   = cnt_q + 3'h1;
                    state_d  = S_IDLE;
                end
                default: begin
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            cmd_q       <= '0;
            calc_q      <= '0;
            fa_q        <= BCS_ADDR_RESET;
            freq_n_q    <= 1'b1;
            fseq_q      <= 1'b0;
            comp_q      <= 1'b0;
            xfer_q      <= 1'b0;
            xfer_pend_q <= 1'b0;
            disc_q      <= 1'b0;
            lwe_q       <= 1'b0;
            ldata_q     <= BCS_ADDR_RESET;
            ret_q       <= 1'b0;
            cnt_q       <= BCS_COST_RESET;
            cost_q      <= BCS_COST_RESET;
            ilk_q       <= BCS_ILK_RESET;
            chg_q       <= 1'b0;
            chgn_q      <= BCS_ILK_RESET;
        end else begin
            state_q     <= state_d;
            cmd_q       <= cmd_d;
            calc_q      <= calc_d;
            fa_q        <= fa_d;
            freq_n_q    <= freq_n_d;
            fseq_q      <= fseq_d;
            comp_q      <= comp_d;
            xfer_q      <= xfer_d;
            xfer_pend_q <= xfer_pend_d;
            disc_q      <= disc_d;
            lwe_q       <= lwe_d;
            ldata_q     <= ldata_d;
            ret_q       <= ret_d;
            cnt_q       <= cnt_d;
            cost_q      <= cost_d;
            ilk_q       <= ilk_d;
            chg_q       <= chg_d;
            chgn_q      <= chgn_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Data side carries only internal cycles during branches
    assign cmd_ready         = (state_q == S_IDLE);
    assign read_word_a_fetch_addr  = fa_q;
    assign read_word_a_mem_req_n   = freq_n_q;
    assign read_word_a_sequential  = fseq_q;
    assign compact_state_out = comp_q;
    assign data_side_addr    = BCS_ADDR_RESET;
    assign data_mem_req_n    = 1'b1;
    assign data_sequential   = 1'b0;
    assign data_xfer_done    = xfer_q;
    assign prefetch_discard  = disc_q;
    assign link_we           = lwe_q;
    assign link_idx          = BCS_LINK_REG;
    assign link_data         = ldata_q;
    assign retire            = ret_q;
    assign retire_cost       = cost_q;
    assign charge_valid      = chg_q;
    assign charge_cycles     = chgn_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_target_fetch;
        !read_word_a_mem_req_n && !read_word_a_sequential && prefetch_discard;
    endsequence

    sequence s_refill_pair;
        !read_word_a_mem_req_n && read_word_a_sequential;
    endsequence

    a_target_then_seq: assert property (
        s_target_fetch ##1 wait_state_gate |=> s_refill_pair)
        else $error("Target fetch not followed by sequential fetch");

    a_step_new_width: assert property (
        (s_target_fetch ##0 wait_state_gate) |=>
        read_word_a_fetch_addr == $past(read_word_a_fetch_addr) +
            (compact_state_out ? BCS_STEP_COMPACT : BCS_STEP_WIDE))
        else $error("Fetch step does not match new width");

    a_refill_step: assert property (
        (s_refill_pair ##0 (state_q == S_B3 && wait_state_gate)) |=>
        read_word_a_fetch_addr == $past(read_word_a_fetch_addr) +
            (compact_state_out ? BCS_STEP_COMPACT : BCS_STEP_WIDE))
        else $error("Refill address off by one step");

    a_cost_three: assert property (
        retire && !(cmd_q.kind == BCS_K_CLINK || cmd_q.kind == BCS_K_CLXIMM)
        |-> retire_cost == 3'h3)
        else $error("Single branch cost not three");

    a_cost_four: assert property (
        retire && (cmd_q.kind == BCS_K_CLINK || cmd_q.kind == BCS_K_CLXIMM)
        |-> retire_cost == 3'h4)
        else $error("Compact linked branch cost not four");

    a_stall_holds: assert property (
        !wait_state_gate |=> $stable(read_word_a_fetch_addr) && $stable(state_q))
        else $error("Outputs moved during a wait state");

    a_old_state_half: assert property (
        (state_q == S_HALF && wait_state_gate) |=>
        compact_state_out == cmd_q.compact && link_we)
        else $error("First half shows wrong state or no r14 write");

    a_data_idle: assert property (
        state_q != S_IDLE |-> data_mem_req_n && !data_sequential)
        else $error("Data request during branch");

    a_link_return: assert property (
        (state_q == S_B2 && wait_state_gate && calc_q.link) |=>
        link_we && link_data == calc_q.ret_addr)
        else $error("Return address not written");

    a_ilk_charge: assert property (
        charge_valid |-> charge_cycles == cmd_q.interlock && state_q == S_B1)
        else $error("Interlock charge wrong");

    a_begin_seq: assert property (
        (take && wait_state_gate && cmd.kind == BCS_K_BRANCH) |=>
        state_q == S_B1 && read_word_a_mem_req_n)
        else $error("Branch walk broken");

    a_b1_target: assert property (
        (state_q == S_B1 && wait_state_gate) |=> s_target_fetch)
        else $error("Target fetch not issued after first cycle");

endmodule

//--- logic/bcs_target_calc.sv
// Branch target, new state and return address calculation
`timescale 1ns/1ns
module bcs_target_calc (
    input  wire bcs_pkg::bcs_cmd_type  cmd,
    output bcs_pkg::bcs_calc_type      calc
);
    import bcs_pkg::*;

    logic [31:0] step;

    always_comb begin
        step             = cmd.compact ? BCS_STEP_COMPACT : BCS_STEP_WIDE;
        calc.hi_sum      = cmd.pc + cmd.imm_hi;
        calc.target      = cmd.pc + cmd.imm_hi;
        calc.new_compact = cmd.compact;
        calc.ret_addr    = (cmd.pc + step) | {31'h0, cmd.compact};
        calc.link        = 1'b0;
        calc.two_part    = 1'b0;
        calc.reg_form    = 1'b0;
        unique case (cmd.kind)
            BCS_K_BRANCH: begin
                calc.link = 1'b0;
            end
            BCS_K_LINK: begin
                calc.link = 1'b1;
            end
            BCS_K_XREG, BCS_K_LXREG: begin
                // Target and new state both come from the register
                calc.target      = cmd.reg_val & BCS_HALF_MASK;
                calc.new_compact = cmd.reg_val[0];
                calc.link        = (cmd.kind == BCS_K_LXREG);
                calc.reg_form    = 1'b1;
            end
            BCS_K_LXIMM: begin
                calc.new_compact = 1'b1;
                calc.link        = 1'b1;
            end
            BCS_K_CLINK, BCS_K_CLXIMM: begin
                // Upper part first, lower offset added to hi_sum recomputed from pc and upper offset
                calc.target   = calc.hi_sum + cmd.imm_lo;
                calc.ret_addr = (cmd.pc + step + step) | 32'h0000_0001;
                calc.link     = 1'b1;
                calc.two_part = 1'b1;
                if (cmd.kind == BCS_K_CLXIMM) begin
                    calc.target      = (calc.hi_sum + cmd.imm_lo) & BCS_WORD_MASK;
                    calc.new_compact = 1'b0;
                end
            end
            default: begin
                calc.link = 1'b0;
            end
        endcase
    end

endmodule

//--- testbench/bcs_mem_model.sv
// Memory-side model: wait-state gate and accepted fetch counter
`timescale 1ns/1ns
module bcs_mem_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic stall_en,
    input  wire logic read_word_a_mem_req_n,
    output logic      wait_state_gate,
    output logic [7:0] fetch_count
);
    logic toggle_q;

    // ************************************************************
    // Gate moves off the sampling edge; stall mode halves the rate
    // ************************************************************
    always @(negedge ref_clk) begin
        toggle_q        <= ~toggle_q & stall_en;
        wait_state_gate <= ~(stall_en & ~toggle_q);
    end

    // ************************************************************
    // Request is announced one cycle early, taken at the enabled edge
    // ************************************************************
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            fetch_count <= 8'h00;
        end else if (wait_state_gate && !read_word_a_mem_req_n) begin
            fetch_count <= fetch_count + 8'h01;
        end
    end
endmodule

//--- testbench/branch_cycle_sequencer_tb_top.sv
// Self-checking bench of the branch cycle sequencer
`timescale 1ns/1ns
module branch_cycle_sequencer_tb_top;
    import bcs_pkg::*;

    logic        ref_clk;
    logic        rst_n;
    logic        stall_en;
    bcs_cmd_type cmd;
    logic        wait_state_gate;
    logic [7:0]  fetch_count;
    logic        cmd_ready;
    logic [31:0] read_word_a_fetch_addr;
    logic        read_word_a_mem_req_n;
    logic        read_word_a_sequential;
    logic        compact_state_out;
    logic [31:0] data_side_addr;
    logic        data_mem_req_n;
    logic        data_sequential;
    logic        data_xfer_done;
    logic        prefetch_discard;
    logic        link_we;
    logic [31:0] link_data;
    logic        retire;
    logic [2:0]  retire_cost;
    logic        charge_valid;
    logic [1:0]  charge_cycles;
    int          miscompares;
    int          n_compared;

    bcs_sequencer u_bcs_sequencer (
        .ref_clk(ref_clk), .rst_n(rst_n), .wait_state_gate(wait_state_gate), .cmd(cmd),
        .cmd_ready(cmd_ready), .read_word_a_fetch_addr(read_word_a_fetch_addr),
        .read_word_a_mem_req_n(read_word_a_mem_req_n), .read_word_a_sequential(read_word_a_sequential),
        .compact_state_out(compact_state_out), .data_side_addr(data_side_addr),
        .data_mem_req_n(data_mem_req_n), .data_sequential(data_sequential),
        .data_xfer_done(data_xfer_done), .prefetch_discard(prefetch_discard),
        .link_we(link_we), .link_idx(), .link_data(link_data), .retire(retire),
        .retire_cost(retire_cost), .charge_valid(charge_valid),
        .charge_cycles(charge_cycles)
    );

    bcs_mem_model u_bcs_mem_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .stall_en(stall_en),
        .read_word_a_mem_req_n(read_word_a_mem_req_n), .wait_state_gate(wait_state_gate),
        .fetch_count(fetch_count)
    );

    // ************************************************************
    // Compare and cycle helpers
    // ************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    // Steps to the next enabled cycle; a held cycle must not move the fetch
    task automatic next_cyc();
        logic [31:0] held;
        held = read_word_a_fetch_addr;
        @(posedge ref_clk);
        while (wait_state_gate !== 1'b1) begin
            @(negedge ref_clk);
            chk_word(read_word_a_fetch_addr, held);
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        chk_word(data_side_addr, 32'h0000_0000);
        chk_bit(data_mem_req_n, 1'b1);
    endtask

    function automatic bcs_cmd_type mk(input bcs_kind_type k, input logic cp,
                                       input logic [1:0] il, input logic [31:0] rv);
        mk = '0;
        mk.kind = k;
        mk.compact = cp;
        mk.prev_data = 1'b1;
        mk.interlock = il;
        mk.pc = 32'h0000_1000;
        mk.imm_hi = 32'h0000_0200;
        mk.imm_lo = 32'h0000_0040;
        mk.reg_val = rv;
    endfunction

    // Presents one command and returns in the first cycle after it is taken
    task automatic take(input bcs_cmd_type c);
        int k;
        bcs_cmd_type v;
        v = c;
        v.valid = 1'b1;
        cmd = v;
        k = 0;
        #1;
        while (!(cmd_ready === 1'b1 && wait_state_gate === 1'b1) && k < 50) begin
            k++;
            @(negedge ref_clk);
            #1;
        end
        @(negedge ref_clk);
        cmd.valid = 1'b0;
    endtask

    // Walks one branch; tk tells whether the target comes from the register value
    task automatic walk(input bcs_cmd_type c, input logic pair, input logic nc, input logic tk,
                        input logic lk, input logic [31:0] ret);
        logic [31:0] t;
        logic [31:0] st;
        logic [7:0]  fc;
        st = nc ? BCS_STEP_COMPACT : BCS_STEP_WIDE;
        t = c.reg_val & (nc ? BCS_HALF_MASK : BCS_WORD_MASK);
        take(c);
        chk_bit(cmd_ready, 1'b0);
        next_cyc();
        for (int n = 1; n <= c.interlock; n++) begin
            if (n == 1) begin
                chk_bit(data_xfer_done, c.prev_data);
            end
            if (n == c.interlock) begin
                chk_bit(charge_valid, 1'b1);
                chk_word(32'(charge_cycles), 32'(c.interlock));
            end
            next_cyc();
        end
        fc = fetch_count;
        if (pair) begin
            chk_word(read_word_a_fetch_addr, c.pc + 32'h0000_0006);
            chk_bit(read_word_a_sequential, 1'b1);
            chk_bit(compact_state_out, c.compact);
            chk_bit(link_we, 1'b1);
            chk_word(link_data, c.pc + c.imm_hi);
            chk_bit(data_xfer_done, c.prev_data);
            next_cyc();
        end else if (c.interlock == 0) begin
            chk_bit(data_xfer_done, c.prev_data);
        end
        if (!tk) begin
            t = (c.pc + c.imm_hi + (pair ? c.imm_lo : 32'h0000_0000))
                & (nc ? BCS_HALF_MASK : BCS_WORD_MASK);
        end
        chk_word(read_word_a_fetch_addr, t);
        chk_bit(read_word_a_mem_req_n, 1'b0);
        chk_bit(read_word_a_sequential, 1'b0);
        chk_bit(prefetch_discard, 1'b1);
        chk_bit(compact_state_out, nc);
        for (int k = 1; k <= 2; k++) begin
            next_cyc();
            chk_word(read_word_a_fetch_addr, t + st * k);
            chk_bit(read_word_a_sequential, 1'b1);
            chk_bit(prefetch_discard, 1'b0);
            chk_bit(compact_state_out, nc);
            if (k == 1) begin
                chk_bit(link_we, lk);
                if (lk) begin
                    chk_word(link_data, ret);
                end
            end
        end
        chk_bit(retire, 1'b1);
        chk_word(32'(retire_cost), pair ? 32'h0000_0004 : 32'h0000_0003);
        next_cyc();
        chk_word(32'(8'(fetch_count - fc)), pair ? 32'h0000_0004 : 32'h0000_0003);
        chk_bit(read_word_a_mem_req_n, 1'b1);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic sc_plain();
        walk(mk(BCS_K_BRANCH, 1'b0, 2'h0, '0), 1'b0, 1'b0, 1'b0, 1'b0, '0);
        walk(mk(BCS_K_BRANCH, 1'b1, 2'h0, '0), 1'b0, 1'b1, 1'b0, 1'b0, '0);
        walk(mk(BCS_K_LINK, 1'b0, 2'h0, '0), 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_1004);
    endtask

    task automatic sc_exchange();
        walk(mk(BCS_K_XREG, 1'b0, 2'h2, 32'h0000_2347), 1'b0, 1'b1, 1'b1, 1'b0, '0);
        walk(mk(BCS_K_LXREG, 1'b1, 2'h0, 32'h0000_3454), 1'b0, 1'b0, 1'b1, 1'b1,
             32'h0000_1003);
        walk(mk(BCS_K_LXIMM, 1'b0, 2'h0, '0), 1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_1004);
    endtask

    task automatic sc_pairs();
        walk(mk(BCS_K_CLINK, 1'b1, 2'h0, '0), 1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_1005);
        walk(mk(BCS_K_CLXIMM, 1'b1, 2'h0, '0), 1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_1005);
    endtask

    task automatic sc_wait_states();
        stall_en = 1'b1;
        walk(mk(BCS_K_BRANCH, 1'b0, 2'h0, '0), 1'b0, 1'b0, 1'b0, 1'b0, '0);
        walk(mk(BCS_K_CLINK, 1'b1, 2'h0, '0), 1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_1005);
        stall_en = 1'b0;
    endtask

    // ************************************************************
    // Verdict, clock, watchdog and main sequence
    // ************************************************************
    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #300_000;
        miscompares++;
        print_verdict();
    end

    initial begin
        miscompares = 0;
        n_compared = 0;
        rst_n = 1'b0;
        stall_en = 1'b0;
        cmd = '0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        chk_bit(read_word_a_mem_req_n, 1'b1);
        chk_bit(cmd_ready, 1'b1);
        sc_plain();
        sc_exchange();
        sc_pairs();
        sc_wait_states();
        print_verdict();
    end
endmodule
